// ==== hdl/buck4_config_registers.sv ====
`timescale 1ns/100ps

// Contract
// - Register 0x4B holds a read/write six-bit standby set point in bits 5:0, reset to zero.
// - Register 0x4C holds a read/write six-bit sleep set point in bits 5:0, reset to zero.
// - Register 0x4D holds a read/write four-bit switching-mode selector in bits 3:0, reset to 8.
// - Bit 5 of 0x4D selects sleep behaviour: 0 turns off, 1 keeps running in PFM; resets to 0.
// - Bit 0 of 0x4E selects the current limit: 0 high level, 1 low level; resets to 0.
// - Bits 3:2 of 0x4E select the switching frequency and reset to zero.
// - Bits 5:4 of 0x4E select the phase clock and reset to zero.
// - Bits 7:6 of 0x4E select the voltage slew speed and reset to zero.
// - Set-point codes 9 to 63 map linearly to 625 mV to 1975 mV in 25 mV steps.
// - Frequency codes 0, 1 and 2 give 1, 2 and 4 MHz.
// - In termination mode after start-up, writes are ignored and only PWM switching is used.
module buck4_config_registers
  import buck4_cfg_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h08,
  parameter logic [3:0] PWM_MODE_CODE = 4'h1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic memory_termination_mode_i,
  input wire logic startup_done_i,
  output logic sda_o,
  output logic sda_oe_o,
  output buck_ctrl_t ctrl_o
);

  function automatic logic [7:0] read_reg(input logic [7:0] addr, input regulator_config_t c);
    read_reg = 8'h00;
    if (addr == ADDR_STANDBY) begin
      read_reg[SETPOINT_LSB +: 6] = c.standby_setpoint;
    end else if (addr == ADDR_SLEEP) begin
      read_reg[SETPOINT_LSB +: 6] = c.sleep_setpoint;
    end else if (addr == ADDR_MODE) begin
      read_reg[MODE_LSB +: 4] = c.switching_mode_select;
      read_reg[SLEEP_BEH_BIT] = c.sleep_behaviour_select;
    end else if (addr == ADDR_CONFIG) begin
      read_reg[ILIM_BIT] = c.current_limit_select;
      read_reg[FREQ_LSB +: 2] = c.frequency_select;
      read_reg[PHASE_LSB +: 2] = c.phase_clock_select;
      read_reg[SLEW_LSB +: 2] = c.slew_speed_select;
    end
  endfunction : read_reg

  function automatic regulator_config_t write_reg(input regulator_config_t c,
                                                  input logic [7:0] addr,
                                                  input logic [7:0] d);
    write_reg = c;
    if (addr == ADDR_STANDBY) begin
      write_reg.standby_setpoint = d[SETPOINT_LSB +: 6];
    end else if (addr == ADDR_SLEEP) begin
      write_reg.sleep_setpoint = d[SETPOINT_LSB +: 6];
    end else if (addr == ADDR_MODE) begin
      write_reg.switching_mode_select = d[MODE_LSB +: 4];
      write_reg.sleep_behaviour_select = d[SLEEP_BEH_BIT];
    end else if (addr == ADDR_CONFIG) begin
      write_reg.current_limit_select = d[ILIM_BIT];
      write_reg.frequency_select = d[FREQ_LSB +: 2];
      write_reg.phase_clock_select = d[PHASE_LSB +: 2];
      write_reg.slew_speed_select = d[SLEW_LSB +: 2];
    end
  endfunction : write_reg

  // codes below the table read as 0 mV
  function automatic logic [10:0] to_mv(input logic [5:0] code);
    if (code < SETPOINT_MIN_CODE) begin
      to_mv = 11'h000;
    end else begin
      to_mv = SETPOINT_MIN_MV + 11'(6'(code - SETPOINT_MIN_CODE)) * SETPOINT_STEP_MV;
    end
  endfunction : to_mv

  // reserved code reads as 0 kHz
  function automatic logic [12:0] to_khz(input logic [1:0] sel);
    unique case (sel)
      FREQ_SEL_1MHZ: to_khz = FREQ_1MHZ_KHZ;
      FREQ_SEL_2MHZ: to_khz = FREQ_2MHZ_KHZ;
      FREQ_SEL_4MHZ: to_khz = FREQ_4MHZ_KHZ;
      default: to_khz = 13'h0000;
    endcase
  endfunction : to_khz

  function automatic buck_ctrl_t derive(input regulator_config_t c, input logic lock);
    derive.cfg = c;
    derive.effective_mode = lock ? PWM_MODE_CODE : c.switching_mode_select;
    derive.standby_target_mv = to_mv(c.standby_setpoint);
    derive.sleep_target_mv = to_mv(c.sleep_setpoint);
    derive.switch_freq_khz = to_khz(c.frequency_select);
  endfunction : derive

  localparam regulator_config_t CFG_RST = '{
    standby_setpoint: SETPOINT_RST,
    sleep_setpoint: SETPOINT_RST,
    switching_mode_select: MODE_RST,
    sleep_behaviour_select: SLEEP_BEH_RST,
    current_limit_select: ILIM_RST,
    frequency_select: SEL2_RST,
    phase_clock_select: SEL2_RST,
    slew_speed_select: SEL2_RST
  };

  localparam block_state_t ST_RST = '{
    phase: BUS_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00, rw: 1'b0, ack_drv: 1'b0,
    master_nack: 1'b0, sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
    ctrl: derive(CFG_RST, 1'b0)
  };

  block_state_t st;
  block_state_t next_st;
  logic lock;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic wr_fire;
  logic [7:0] rd_byte;

  assign lock = memory_termination_mode_i & startup_done_i;
  assign start_cond = st.scl_q & scl_i & st.sda_q & ~sda_i;
  assign stop_cond = st.scl_q & scl_i & ~st.sda_q & sda_i;
  assign scl_rise = scl_i & ~st.scl_q;
  assign scl_fall = ~scl_i & st.scl_q;
  assign wr_fire = scl_fall & (st.phase == BUS_WRITE) & ~st.ack_drv & (st.bitcnt == BYTE_BITS);
  assign rd_byte = read_reg(st.ptr, st.ctrl.cfg);

  always_comb begin
    next_st = st;
    next_st.scl_q = scl_i;
    next_st.sda_q = sda_i;
    if (start_cond) begin
      next_st.phase = BUS_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.ack_drv = 1'b0;
      next_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st.phase = BUS_IDLE;
      next_st.ack_drv = 1'b0;
      next_st.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (st.phase == BUS_READ) begin
        if (st.bitcnt == BYTE_BITS) begin
          next_st.master_nack = sda_i;
        end
      end else if (st.phase != BUS_IDLE && st.bitcnt != BYTE_BITS) begin
        next_st.shreg = {st.shreg[6:0], sda_i};
        next_st.bitcnt = st.bitcnt + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (st.phase)
        BUS_IDLE: begin
        end
        BUS_ADDR, BUS_PTR, BUS_WRITE: begin
          if (st.ack_drv) begin
            next_st.ack_drv = 1'b0;
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = 4'h0;
            if (st.phase == BUS_ADDR && st.rw) begin
              next_st.phase = BUS_READ;
              next_st.shreg = rd_byte;
              next_st.sda_oe = ~rd_byte[7];
            end else if (st.phase == BUS_ADDR) begin
              next_st.phase = BUS_PTR;
            end else begin
              next_st.phase = BUS_WRITE;
            end
          end else if (st.bitcnt == BYTE_BITS) begin
            if (st.phase == BUS_ADDR && st.shreg[7:1] != DEVICE_ADDR) begin
              next_st.phase = BUS_IDLE;
            end else begin
              next_st.ack_drv = 1'b1;
              next_st.sda_oe = 1'b1;
              if (st.phase == BUS_ADDR) begin
                next_st.rw = st.shreg[0];
              end else if (st.phase == BUS_PTR) begin
                next_st.ptr = st.shreg;
              end else begin
                next_st.ptr = st.ptr + 8'h01;
              end
            end
          end
        end
        BUS_READ: begin
          if (st.bitcnt == BYTE_BITS) begin
            if (st.master_nack) begin
              next_st.phase = BUS_IDLE;
              next_st.sda_oe = 1'b0;
            end else begin
              next_st.ptr = st.ptr + 8'h01;
              next_st.shreg = read_reg(st.ptr + 8'h01, st.ctrl.cfg);
              next_st.sda_oe = ~next_st.shreg[7];
              next_st.bitcnt = 4'h0;
            end
          end else if (st.bitcnt == LAST_DATA_BIT) begin
            next_st.sda_oe = 1'b0;
            next_st.bitcnt = BYTE_BITS;
          end else begin
            next_st.shreg = {st.shreg[6:0], 1'b0};
            next_st.sda_oe = ~st.shreg[6];
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
        end
        default: begin
          next_st.phase = BUS_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
    if (wr_fire && !lock) begin
      next_st.ctrl.cfg = write_reg(st.ctrl.cfg, st.ptr, st.shreg);
    end
    next_st.ctrl = derive(next_st.ctrl.cfg, lock);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = st.sda_oe;
  assign ctrl_o = st.ctrl;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_standby_write: assert property (wr_fire && !lock && st.ptr == ADDR_STANDBY |=>
    ctrl_o.cfg.standby_setpoint == $past(st.shreg[5:0])) else $error("standby write lost");
  a_sleep_write: assert property (wr_fire && !lock && st.ptr == ADDR_SLEEP |=>
    ctrl_o.cfg.sleep_setpoint == $past(st.shreg[5:0])) else $error("sleep write lost");
  a_mode_write: assert property (wr_fire && !lock && st.ptr == ADDR_MODE |=>
    ctrl_o.cfg.switching_mode_select == $past(st.shreg[3:0])) else $error("mode write lost");
  a_sleep_behaviour: assert property (wr_fire && !lock && st.ptr == ADDR_MODE |=>
    ctrl_o.cfg.sleep_behaviour_select == $past(st.shreg[5])) else $error("sleep bit lost");
  a_ilim_write: assert property (wr_fire && !lock && st.ptr == ADDR_CONFIG |=>
    ctrl_o.cfg.current_limit_select == $past(st.shreg[0])) else $error("ilim write lost");
  a_freq_write: assert property (wr_fire && !lock && st.ptr == ADDR_CONFIG |=>
    ctrl_o.cfg.frequency_select == $past(st.shreg[3:2])) else $error("freq write lost");
  a_phase_write: assert property (wr_fire && !lock && st.ptr == ADDR_CONFIG |=>
    ctrl_o.cfg.phase_clock_select == $past(st.shreg[5:4])) else $error("phase write lost");
  a_slew_write: assert property (wr_fire && !lock && st.ptr == ADDR_CONFIG |=>
    ctrl_o.cfg.slew_speed_select == $past(st.shreg[7:6])) else $error("slew write lost");
  a_setpoint_map: assert property (ctrl_o.cfg.standby_setpoint >= 6'h09 |->
    ctrl_o.standby_target_mv == 11'(625 + (ctrl_o.cfg.standby_setpoint - 9) * 25))
    else $error("set-point mapping wrong");
  a_freq_map: assert property (ctrl_o.cfg.frequency_select == 2'h2 |->
    ctrl_o.switch_freq_khz == 13'h0fa0) else $error("4 MHz code wrong");
  a_lock_hold: assert property (lock && wr_fire ##1 lock |->
    $stable(ctrl_o.cfg) && ctrl_o.effective_mode == PWM_MODE_CODE) else $error("lock broken");
  a_unused_zero: assert property (st.ptr == ADDR_MODE |->
    rd_byte[7:6] == 2'h0 && rd_byte[4] == 1'b0) else $error("unused bits set");

  c_write_standby: cover property (wr_fire && st.ptr == ADDR_STANDBY);
  c_read_config: cover property (st.phase == BUS_READ && st.ptr == ADDR_CONFIG ##1
    st.phase == BUS_IDLE);
  c_locked_write: cover property (wr_fire && lock);

endmodule : buck4_config_registers

// ==== inc/buck4_cfg_pkg.sv ====
package buck4_cfg_pkg;

  // register map
  localparam logic [7:0] ADDR_STANDBY = 8'h4b;
  localparam logic [7:0] ADDR_SLEEP = 8'h4c;
  localparam logic [7:0] ADDR_MODE = 8'h4d;
  localparam logic [7:0] ADDR_CONFIG = 8'h4e;

  // field positions
  localparam int SETPOINT_LSB = 0;
  localparam int MODE_LSB = 0;
  localparam int SLEEP_BEH_BIT = 5;
  localparam int ILIM_BIT = 0;
  localparam int FREQ_LSB = 2;
  localparam int PHASE_LSB = 4;
  localparam int SLEW_LSB = 6;

  // reset values
  localparam logic [5:0] SETPOINT_RST = 6'h00;
  localparam logic [3:0] MODE_RST = 4'h8;
  localparam logic SLEEP_BEH_RST = 1'b0;
  localparam logic ILIM_RST = 1'b0;
  localparam logic [1:0] SEL2_RST = 2'h0;

  // set-point coding: 625 mV at code 9, 25 mV per step
  localparam logic [5:0] SETPOINT_MIN_CODE = 6'h09;
  localparam logic [10:0] SETPOINT_MIN_MV = 11'h271;
  localparam logic [10:0] SETPOINT_STEP_MV = 11'h019;

  // switching frequency coding
  localparam logic [1:0] FREQ_SEL_1MHZ = 2'h0;
  localparam logic [1:0] FREQ_SEL_2MHZ = 2'h1;
  localparam logic [1:0] FREQ_SEL_4MHZ = 2'h2;
  localparam logic [12:0] FREQ_1MHZ_KHZ = 13'h3e8;
  localparam logic [12:0] FREQ_2MHZ_KHZ = 13'h7d0;
  localparam logic [12:0] FREQ_4MHZ_KHZ = 13'hfa0;

  // serial port framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_PTR = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_READ = 3'b100
  } bus_phase_t;

  typedef struct packed {
    logic [5:0] standby_setpoint;
    logic [5:0] sleep_setpoint;
    logic [3:0] switching_mode_select;
    logic sleep_behaviour_select;
    logic current_limit_select;
    logic [1:0] frequency_select;
    logic [1:0] phase_clock_select;
    logic [1:0] slew_speed_select;
  } regulator_config_t;

  typedef struct packed {
    regulator_config_t cfg;
    logic [3:0] effective_mode;
    logic [10:0] standby_target_mv;
    logic [10:0] sleep_target_mv;
    logic [12:0] switch_freq_khz;
  } buck_ctrl_t;

  typedef struct packed {
    bus_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic ack_drv;
    logic master_nack;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    buck_ctrl_t ctrl;
  } block_state_t;

endpackage : buck4_cfg_pkg

// ==== testbench/host_i2c_model.sv ====
`timescale 1ns/100ps
module host_i2c_model #(
  parameter logic [6:0] DEVICE_ADDR = 7'h08
) (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : tick
  // one scl pulse, line sampled mid high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_o = b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    s = sda_i;
    tick(2);
    scl_o = 1'b0;
    tick(2);
  endtask : clk_bit
  // also serves as repeated start
  task automatic start_cond();
    sda_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
    tick(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start_cond();
    send_byte({DEVICE_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    send_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg
  // single byte, ended by master nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, s;
    start_cond();
    send_byte({DEVICE_ADDR, 1'b0}, k0);
    send_byte(a, k1);
    start_cond();
    send_byte({DEVICE_ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(1'b1, s);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg
  task automatic probe(input logic [6:0] a, output logic ack);
    start_cond();
    send_byte({a, 1'b0}, ack);
    stop_cond();
  endtask : probe
endmodule : host_i2c_model

// ==== testbench/tb_buck4_config_registers.sv ====
`timescale 1ns/100ps
module tb_buck4_config_registers
  import buck4_cfg_pkg::*;
;
  logic sys_clk, rst_n, scl, sda_m, sda_line, term_mode, startup_done, sda_oe, sda_d, ok;
  logic [7:0] d;
  buck_ctrl_t ctrl;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] addrs [4] = '{8'h4b, 8'h4c, 8'h4d, 8'h4e};
  logic [7:0] rst_val [4] = '{8'h00, 8'h00, 8'h08, 8'h00};
  logic [7:0] ones_val [4] = '{8'h3f, 8'h3f, 8'h2f, 8'hfd};
  logic [5:0] codes [4] = '{6'h08, 6'h09, 6'h2a, 6'h3f};
  logic [15:0] mv [4] = '{16'h0000, 16'h0271, 16'h05aa, 16'h07b7};
  logic [15:0] khz [4] = '{16'h03e8, 16'h07d0, 16'h0fa0, 16'h0000};
  // open drain line with pull-up
  assign sda_line = sda_m & (sda_oe ? sda_d : 1'b1);
  always #12.5 sys_clk = ~sys_clk;
  buck4_config_registers dut (
    .sys_clk_i(sys_clk),
    .rst_n_i(rst_n),
    .scl_i(scl),
    .sda_i(sda_line),
    .memory_termination_mode_i(term_mode),
    .startup_done_i(startup_done),
    .sda_o(sda_d),
    .sda_oe_o(sda_oe),
    .ctrl_o(ctrl)
  );
  host_i2c_model host (
    .sys_clk_i(sys_clk),
    .sda_i(sda_line),
    .scl_o(scl),
    .sda_o(sda_m)
  );
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.write_reg(a, v, ok);
    check(16'(ok), 16'h0001, "write ack");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, d, ok);
    check(16'(ok), 16'h0001, "read ack");
    check(16'(d), 16'(exp), "read data");
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    term_mode = 1'b0;
    startup_done = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(16'(ctrl.cfg[23:12]), 16'h0000, "set points reset");
    check(16'(ctrl.cfg[7:0]), 16'h0000, "fields reset");
    check(16'(ctrl.cfg.switching_mode_select), 16'h0008, "mode reset");
    check(16'(ctrl.switch_freq_khz), 16'h03e8, "freq reset");
    for (int i = 0; i < 4; i++) begin
      rd(addrs[i], rst_val[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], ones_val[i]);
    end
    check(16'(ctrl.cfg), 16'(24'h3f_ffff), "cfg ones");
    check(16'(ctrl.cfg[23:12]), 16'h0fff, "set points ones");
    check(16'(ctrl.effective_mode), 16'h000f, "mode follows");
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], 8'h00);
      rd(addrs[i], 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_STANDBY, {2'h3, codes[i]});
      wr(ADDR_SLEEP, {2'h3, codes[i]});
      check(16'(ctrl.standby_target_mv), mv[i], "standby mv");
      check(16'(ctrl.sleep_target_mv), mv[i], "sleep mv");
    end
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CONFIG, {2'(f), 2'(f), 2'(f), 1'b1, 1'(f)});
      check(16'(ctrl.switch_freq_khz), khz[f], "freq khz");
      check(16'(ctrl.cfg[7:0]), 16'({1'b0, 1'(f), 2'(f), 2'(f), 2'(f)}), "cfg fields");
      rd(ADDR_CONFIG, {2'(f), 2'(f), 2'(f), 1'b0, 1'(f)});
    end
    wr(8'h4f, 8'hff);
    rd(8'h4f, 8'h00);
    rd(ADDR_STANDBY, 8'h3f);
    host.probe(7'h09, ok);
    check(16'(ok), 16'h0000, "foreign address ack");
    term_mode = 1'b1;
    wr(ADDR_MODE, 8'h03);
    check(16'(ctrl.effective_mode), 16'h0003, "pre lock mode");
    startup_done = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(16'(ctrl.effective_mode), 16'h0001, "locked pwm");
    wr(ADDR_MODE, 8'h2c);
    wr(ADDR_STANDBY, 8'h20);
    rd(ADDR_MODE, 8'h03);
    rd(ADDR_STANDBY, 8'h3f);
    term_mode = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(16'(ctrl.effective_mode), 16'h0003, "unlocked mode");
    wr(ADDR_MODE, 8'h2f);
    wr(ADDR_CONFIG, 8'hfd);
    rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(16'(ctrl.cfg[23:12]), 16'h0000, "set points second reset");
    check(16'(ctrl.cfg[7:0]), 16'h0000, "fields second reset");
    rd(ADDR_MODE, 8'h08);
    rd(ADDR_CONFIG, 8'h00);
    summarize();
  end
endmodule : tb_buck4_config_registers
